// ### rtl/rcdl_params.svh
// offsets, field positions, codes and reset values of the ramp command decoder
`ifndef RCDL_PARAMS_SVH
`define RCDL_PARAMS_SVH

// register offsets
`define RCDL_A_CMD16     8'h00
`define RCDL_A_CMD8      8'h01
`define RCDL_A_QSTAT     8'h04
`define RCDL_A_INPUT     8'h06
`define RCDL_A_FUNC      8'h07

// command word bit positions
`define RCDL_B_WSYNC     4
`define RCDL_B_SPOL      5
`define RCDL_B_LATCH     6
`define RCDL_B_OVR       7
`define RCDL_B_ENDPOS    12
`define RCDL_B_ENDTIM    13
`define RCDL_B_SOUT      14
`define RCDL_B_CLRT      15

// input status bit positions
`define RCDL_I_SLD_R     0
`define RCDL_I_SLD_L     1
`define RCDL_I_STOP_R    2
`define RCDL_I_STOP_L    3
`define RCDL_I_SYNC      4

// function enable bits
`define RCDL_F_STOP      0
`define RCDL_F_SLD       1
`define RCDL_FUNC_RST    2'h1

// opcodes of the low nibble
`define RCDL_OP_LIN      4'h1
`define RCDL_OP_AUTO     4'h3
`define RCDL_OP_RAMP_MAX 4'h3
`define RCDL_OP_ANA      4'h8

// parameter selectors
`define RCDL_SEL_ANOM    4'h0
`define RCDL_SEL_VNOM    4'h1
`define RCDL_SEL_AACC    4'h2
`define RCDL_SEL_AVEL    4'h3
`define RCDL_SEL_ASLD    4'h4
`define RCDL_SEL_VSLD    4'h5
`define RCDL_SEL_SLOPE   4'h6
`define RCDL_SEL_DIV     4'h7
`define RCDL_SEL_MISC    4'he
`define RCDL_SEL_NONE    4'hf
`define RCDL_SEL_IMOT0   4'h4

`endif

// ### rtl/rcdl_pkg.sv
// types of the ramp command decoder
package rcdl_pkg;
  typedef enum logic {RCDL_FREE, RCDL_BUSY} rcdl_exec_t;
endpackage

// ### rtl/rcdl_top.sv
// ramp command decoder with queue, limit switches and status registers
// Operation
// [R01] 8-bit command keeps bits 12..15
// [R02] selectors 0..3 load 14-bit signed ramp values
// [R03] selectors 4..7 load slowdown, slope, divider
// [R04] selector 14 loads misc, 15 nothing
// [R05] host right-aligns values at destination width
// [R06] target ends command only if bit 12; the automatic ramp (opcode 3) ends at target whatever bit 12 holds
// [R07] time limit ends command only if bit 13
// [R08] bit 14 drives sync output level
// [R09] bit 15 clears time counter at start
// [R10] current write loads thresholds and current levels
// [R11] queue status low bits give entry count
// [R12] stop flag set, cleared by status read
// [R13] slowdown flag set, cleared by status read
// [R14] input status shows switches and sync
// [R15] function register enables stop and slowdown
// [R16] matching stop pulse zeroes velocity, halts
// [R17] slowdown decelerates linearly to slowdown velocity
// [R18] slowdown during automatic ramp stops at once
// [R19] host cancels ramp while slowdown active
// [R20] reference search: override, sync wait, latch
// [R21] bit 4 waits for sync polarity bit 5
// [R22] bit 6 latches holding registers, raises interrupt
// [R23] reactions gated by enables, inputs still visible
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "rcdl_params.svh"
module rcdl_top #(
  parameter int DEPTH = 7
) (
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_NRST,
  // register port
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // switch and sync pins
  input  wire logic        I_LEFT_STOP_PIN_N,
  input  wire logic        I_RIGHT_STOP_PIN_N,
  input  wire logic        I_LEFT_SLOWDOWN_PIN_N,
  input  wire logic        I_RIGHT_SLOWDOWN_PIN_N,
  input  wire logic        I_SYNC_IN,
  // ramp integrator feedback
  input  wire logic        I_ACCEL_REACHED,
  input  wire logic        I_VEL_REACHED,
  input  wire logic        I_TARGET_REACHED,
  input  wire logic        I_TIME_LIMIT_HIT,
  // ramp control
  output logic      [3:0]  O_RAMP_MODE,
  output logic             O_RAMP_HALT,
  output logic             O_RAMP_TICK,
  output logic      [23:0] O_RAMP_TIME,
  output logic             O_SYNC_OUT,
  output logic             O_LATCH,
  output logic             O_QUEUE_IRQ,
  // ramp parameters
  output logic      [13:0] O_NOM_ACCEL,
  output logic      [13:0] O_NOM_VEL,
  output logic      [13:0] O_ACT_ACCEL,
  output logic      [13:0] O_ACT_VEL,
  output logic      [12:0] O_SLD_ACCEL,
  output logic      [12:0] O_SLD_VEL,
  output logic      [13:0] O_ACCEL_SLOPE,
  output logic      [3:0]  O_RAMP_DIV,
  output logic      [1:0]  O_MISC_CTRL,
  // current control parameters
  output logic      [12:0] O_CMP_THRESH [4],
  output logic      [7:0]  O_MOTOR_CURRENT [4]
);

  initial begin
    if (DEPTH < 1 || DEPTH > 7) $error("DEPTH must be 1..7");
  end

  logic [4:0]  pin_s1_reg;
  logic [4:0]  pin_s2_reg;
  logic [4:0]  in_prev_reg;
  logic [4:0]  in_state;
  logic [1:0]  func_reg;
  logic [3:0]  hi_reg;
  logic [15:0] q_cmd_reg [DEPTH];
  logic [15:0] q_val_reg [DEPTH];
  logic [2:0]  head_reg;
  logic [2:0]  tail_reg;
  logic [2:0]  count_reg;
  logic [2:0]  force_reg;
  logic [15:0] head_cmd;
  logic [15:0] head_val;
  logic [3:0]  sel;
  logic        is_ana;
  logic        sync_ok;
  logic        forcing;
  logic        pop;
  logic        run;
  logic        wr_cmd;
  logic        wr_ok;
  logic [15:0] new_cmd;
  rcdl_pkg::rcdl_exec_t state_reg;
  logic [3:0]  mode_reg;
  logic        end_pos_reg;
  logic        end_time_reg;
  logic        halt_reg;
  logic        sync_out_reg;
  logic        latch_reg;
  logic        irq_reg;
  logic        cmd_done;
  logic [15:0] div_cnt_reg;
  logic [15:0] tick_mask;
  logic        tick;
  logic        tick_reg;
  logic [23:0] time_reg;
  logic        dir_right;
  logic        stop_fire;
  logic        sld_act;
  logic        sld_kill;
  logic        stop_flag_reg;
  logic        sld_flag_reg;
  logic        rd_q;
  logic [13:0] mag;
  logic [13:0] nmag;
  logic [13:0] sld_vel_next;
  logic [13:0] nom_accel_reg;
  logic [13:0] nom_vel_reg;
  logic [13:0] act_accel_reg;
  logic [13:0] act_vel_reg;
  logic [12:0] sld_accel_reg;
  logic [12:0] sld_vel_reg;
  logic [13:0] slope_reg;
  logic [3:0]  div_reg;
  logic [1:0]  misc_reg;
  logic [12:0] thr_reg [4];
  logic [7:0]  cur_reg [4];
  logic [31:0] rdata_reg;

  // pins are asynchronous: two flops before use
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      pin_s1_reg  <= 5'h0f;
      pin_s2_reg  <= 5'h0f;
      in_prev_reg <= 5'h00;
    end else begin
      pin_s1_reg  <= {I_SYNC_IN, I_LEFT_STOP_PIN_N, I_RIGHT_STOP_PIN_N,
                      I_LEFT_SLOWDOWN_PIN_N, I_RIGHT_SLOWDOWN_PIN_N};
      pin_s2_reg  <= pin_s1_reg;
      in_prev_reg <= in_state;
    end
  end

  // switches are active low, sync is shown as its level
  assign in_state = {pin_s2_reg[`RCDL_I_SYNC], ~pin_s2_reg[`RCDL_I_STOP_L:`RCDL_I_SLD_R]};

  // positive velocity means increasing position, i.e. the right switch
  assign dir_right = ~act_vel_reg[13];
  assign stop_fire = func_reg[`RCDL_F_STOP] &                      // see [R23]
    (dir_right ? in_state[`RCDL_I_STOP_R] & ~in_prev_reg[`RCDL_I_STOP_R]
               : in_state[`RCDL_I_STOP_L] & ~in_prev_reg[`RCDL_I_STOP_L]); // see [R16]
  assign sld_act = func_reg[`RCDL_F_SLD] &                         // see [R23]
    (dir_right ? in_state[`RCDL_I_SLD_R] : in_state[`RCDL_I_SLD_L]);
  // slowdown is meaningless for the automatic ramp, so it is killed outright
  assign sld_kill = sld_act & (state_reg == rcdl_pkg::RCDL_BUSY) &
                    (mode_reg == `RCDL_OP_AUTO);                   // see [R18]

  // ramp clock: f_clk / 2^(div+1)
  assign tick_mask = 16'hffff >> (4'hf - div_reg);
  assign tick      = (div_cnt_reg & tick_mask) == tick_mask;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      div_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
      tick_reg    <= tick;
    end
  end

  // command queue write side
  assign wr_cmd  = I_WR && (I_ADDR == `RCDL_A_CMD16 || I_ADDR == `RCDL_A_CMD8);
  assign wr_ok   = wr_cmd && (count_reg != 3'(DEPTH));
  assign new_cmd = (I_ADDR == `RCDL_A_CMD16) ? I_WDATA[15:0]
                 : {hi_reg, `RCDL_SEL_NONE, I_WDATA[7:0]};           // see [R01]

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      hi_reg <= 4'h0;
    end else if (wr_ok && I_ADDR == `RCDL_A_CMD16) begin
      hi_reg <= I_WDATA[15:12];                                      // see [R01]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
          q_cmd_reg[gi] <= 16'h0000;
          q_val_reg[gi] <= 16'h0000;
        end else if (wr_ok && tail_reg == 3'(gi)) begin
          q_cmd_reg[gi] <= new_cmd;
          q_val_reg[gi] <= I_WDATA[31:16];
        end
      end
    end
  endgenerate

  // queue read side
  assign head_cmd = q_cmd_reg[head_reg];
  assign head_val = q_val_reg[head_reg];
  assign sel      = head_cmd[11:8];
  assign is_ana   = head_cmd[3:0] == `RCDL_OP_ANA;
  assign sync_ok  = !head_cmd[`RCDL_B_WSYNC] ||
                    (in_state[`RCDL_I_SYNC] == head_cmd[`RCDL_B_SPOL]); // see [R21]
  assign forcing  = force_reg != 3'h0;
  // entries ahead of an override go at once; the override itself cuts the
  // running ramp but still honours its own sync wait
  assign pop = (count_reg != 3'h0) &&
               (force_reg > 3'h1 ||
                ((state_reg == rcdl_pkg::RCDL_FREE || force_reg == 3'h1) && sync_ok)); // see [R20]
  assign run = pop && (!forcing || force_reg == 3'h1);

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      head_reg  <= 3'h0;
      tail_reg  <= 3'h0;
      count_reg <= 3'h0;
      force_reg <= 3'h0;
    end else begin
      if (wr_ok) tail_reg <= (tail_reg == 3'(DEPTH - 1)) ? 3'h0 : tail_reg + 3'h1;
      if (pop) head_reg <= (head_reg == 3'(DEPTH - 1)) ? 3'h0 : head_reg + 3'h1;
      count_reg <= count_reg + 3'(wr_ok) - 3'(pop);                 // see [R11]
      if (wr_ok && new_cmd[`RCDL_B_OVR]) begin
        force_reg <= count_reg + 3'h1 - 3'(pop);                     // see [R20]
      end else if (pop && forcing) begin
        force_reg <= force_reg - 3'h1;
      end
    end
  end

  // termination of the running ramp command
  assign cmd_done = (mode_reg == `RCDL_OP_AUTO)
                  ? I_TARGET_REACHED || (end_time_reg && I_TIME_LIMIT_HIT)
                  : (end_pos_reg && I_TARGET_REACHED) ||                // see [R06]
                    (end_time_reg && I_TIME_LIMIT_HIT);                 // see [R07]

  // slowdown step toward the slowdown velocity, keeping the sign
  always_comb begin
    mag  = act_vel_reg[13] ? 14'(-act_vel_reg) : act_vel_reg;
    nmag = mag;
    if (mag > {1'b0, sld_vel_reg}) begin
      if (mag > {1'b0, sld_accel_reg} &&
          (mag - {1'b0, sld_accel_reg}) > {1'b0, sld_vel_reg}) begin
        nmag = mag - {1'b0, sld_accel_reg};
      end else begin
        nmag = {1'b0, sld_vel_reg};
      end
    end
    sld_vel_next = act_vel_reg[13] ? 14'(-nmag) : nmag;
  end

  // command execution, velocity and stop reactions
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      state_reg    <= rcdl_pkg::RCDL_FREE;
      mode_reg     <= 4'h0;
      end_pos_reg  <= 1'b0;
      end_time_reg <= 1'b0;
      halt_reg     <= 1'b0;
      sync_out_reg <= 1'b0;
      latch_reg    <= 1'b0;
      irq_reg      <= 1'b0;
      act_vel_reg  <= 14'h0000;
    end else begin
      latch_reg <= run && head_cmd[`RCDL_B_LATCH];                 // see [R22]
      irq_reg   <= run && head_cmd[`RCDL_B_LATCH];                 // see [R22]
      if (run) begin
        sync_out_reg <= head_cmd[`RCDL_B_SOUT];                    // see [R08]
        end_pos_reg  <= head_cmd[`RCDL_B_ENDPOS];                  // see [R06]
        end_time_reg <= head_cmd[`RCDL_B_ENDTIM];                  // see [R07]
        if (head_cmd[3:0] <= `RCDL_OP_RAMP_MAX) begin
          mode_reg  <= head_cmd[3:0];
          halt_reg  <= 1'b0;
          state_reg <= rcdl_pkg::RCDL_BUSY;
        end
      end else if (state_reg == rcdl_pkg::RCDL_BUSY && cmd_done) begin
        state_reg <= rcdl_pkg::RCDL_FREE;
      end
      if (stop_fire || sld_kill) begin
        act_vel_reg <= 14'h0000;                                   // see [R16]
        halt_reg    <= 1'b1;
        state_reg   <= rcdl_pkg::RCDL_FREE;                        // see [R18]
      end else if (pop && !is_ana && sel == `RCDL_SEL_AVEL) begin
        act_vel_reg <= head_val[13:0];                             // see [R02]
      end else if (sld_act && tick) begin
        mode_reg    <= `RCDL_OP_LIN;                               // see [R17]
        act_vel_reg <= sld_vel_next;                               // see [R17]
      end
    end
  end

  // ramp time counter
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      time_reg <= 24'h000000;
    end else if (run && head_cmd[`RCDL_B_CLRT]) begin
      time_reg <= 24'h000000;                                      // see [R09]
    end else if (tick) begin
      time_reg <= time_reg + 24'h000001;
    end
  end

  // ramp parameter loads; values are taken right-aligned
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      nom_accel_reg <= 14'h0000;
      nom_vel_reg   <= 14'h0000;
      act_accel_reg <= 14'h0000;
      sld_accel_reg <= 13'h0000;
      sld_vel_reg   <= 13'h0000;
      slope_reg     <= 14'h0000;
      div_reg       <= 4'h0;
      misc_reg      <= 2'h0;
    end else if (pop && !is_ana) begin
      case (sel)
        `RCDL_SEL_ANOM:  nom_accel_reg <= head_val[13:0];          // see [R02]
        `RCDL_SEL_VNOM:  nom_vel_reg   <= head_val[13:0];          // see [R02]
        `RCDL_SEL_AACC:  act_accel_reg <= head_val[13:0];          // see [R02]
        `RCDL_SEL_ASLD:  sld_accel_reg <= head_val[12:0];          // see [R03]
        `RCDL_SEL_VSLD:  sld_vel_reg   <= head_val[12:0];          // see [R03]
        `RCDL_SEL_SLOPE: slope_reg     <= head_val[13:0];          // see [R03]
        `RCDL_SEL_DIV:   div_reg       <= head_val[3:0];           // see [R03]
        `RCDL_SEL_MISC:  misc_reg      <= head_val[1:0];           // see [R04]
        default: ;                                                 // see [R04]
      endcase
    end
  end

  generate
    for (gi = 0; gi < 4; gi++) begin : g_ana
      always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
          thr_reg[gi] <= 13'h0000;
          cur_reg[gi] <= 8'h00;
        end else if (pop && is_ana) begin
          if (sel == 4'(gi)) thr_reg[gi] <= head_val[12:0];        // see [R10]
          if (sel == `RCDL_SEL_IMOT0 + 4'(gi)) begin
            cur_reg[gi] <= head_val[7:0];                          // see [R10]
          end
        end
      end
      assign O_CMP_THRESH[gi]    = thr_reg[gi];
      assign O_MOTOR_CURRENT[gi] = cur_reg[gi];
    end
  endgenerate

  // event flags: a new event wins over the read that clears
  assign rd_q = I_RD && I_ADDR == `RCDL_A_QSTAT;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      stop_flag_reg <= 1'b0;
      sld_flag_reg  <= 1'b0;
    end else begin
      stop_flag_reg <= stop_fire || (stop_flag_reg && !rd_q);      // see [R12]
      sld_flag_reg  <= sld_act || (sld_flag_reg && !rd_q);         // see [R13]
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      func_reg <= `RCDL_FUNC_RST;
    end else if (I_WR && I_ADDR == `RCDL_A_FUNC) begin
      func_reg <= I_WDATA[1:0];                                    // see [R15]
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST || !I_RD) begin
      rdata_reg <= 32'h00000000;
    end else begin
      case (I_ADDR)
        `RCDL_A_QSTAT: rdata_reg <= {18'h00000, sld_flag_reg, stop_flag_reg,
          (state_reg == rcdl_pkg::RCDL_BUSY && mode_reg == `RCDL_OP_AUTO),
          I_TARGET_REACHED, I_VEL_REACHED, I_ACCEL_REACHED, 5'h00, count_reg}; // see [R11]
        `RCDL_A_INPUT: rdata_reg <= {27'h0000000, in_state};       // see [R14]
        `RCDL_A_FUNC:  rdata_reg <= {30'h00000000, func_reg};
        default:       rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign O_RDATA       = rdata_reg;
  assign O_RAMP_MODE   = mode_reg;
  assign O_RAMP_HALT   = halt_reg;
  assign O_RAMP_TICK   = tick_reg;
  assign O_RAMP_TIME   = time_reg;
  assign O_SYNC_OUT    = sync_out_reg;
  assign O_LATCH       = latch_reg;
  assign O_QUEUE_IRQ   = irq_reg;
  assign O_NOM_ACCEL   = nom_accel_reg;
  assign O_NOM_VEL     = nom_vel_reg;
  assign O_ACT_ACCEL   = act_accel_reg;
  assign O_ACT_VEL     = act_vel_reg;
  assign O_SLD_ACCEL   = sld_accel_reg;
  assign O_SLD_VEL     = sld_vel_reg;
  assign O_ACCEL_SLOPE = slope_reg;
  assign O_RAMP_DIV    = div_reg;
  assign O_MISC_CTRL   = misc_reg;

  a_stop_zero_vel: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // see [R16]
    stop_fire |=> act_vel_reg == 14'h0000 && stop_flag_reg && halt_reg)
    else $error("stop did not zero velocity");
  a_stop_flag_clr: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // see [R12]
    rd_q && !stop_fire |=> !stop_flag_reg)
    else $error("stop flag not cleared by read");
  a_sld_flag_set: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // see [R13]
    sld_act |=> sld_flag_reg)
    else $error("slowdown flag not set");
  a_count_incr: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // see [R11]
    wr_ok && !pop |=> count_reg == $past(count_reg) + 3'h1)
    else $error("queue count wrong after write");
  a_timer_clear: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // see [R09]
    run && head_cmd[`RCDL_B_CLRT] |=> time_reg == 24'h000000)
    else $error("time counter not cleared");
  a_sync_wait: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // see [R21]
    count_reg != 3'h0 && !forcing && !sync_ok |-> !pop)
    else $error("command left queue before sync");
  a_latch_pulse: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // see [R22]
    run && head_cmd[`RCDL_B_LATCH] |=> O_LATCH && O_QUEUE_IRQ)
    else $error("latch and interrupt not raised");
  a_cmd8_keep: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // see [R01]
    wr_ok && I_ADDR == `RCDL_A_CMD8 |=> hi_reg == $past(hi_reg))
    else $error("short command changed upper bits");
  a_time_gate: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // see [R07]
    state_reg == rcdl_pkg::RCDL_BUSY && mode_reg != `RCDL_OP_AUTO && !end_time_reg
    && !end_pos_reg && !stop_fire && !sld_kill && !run |=> state_reg == rcdl_pkg::RCDL_BUSY)
    else $error("command ended without enabled condition");
  a_sync_out: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // see [R08]
    run |=> O_SYNC_OUT == $past(head_cmd[`RCDL_B_SOUT]))
    else $error("sync output not taken from command");

endmodule

// ### sim/rcdl_host.sv
// host model that reaches the ramp command decoder over its register port
`timescale 1ns/1ps
`include "rcdl_params.svh"
module rcdl_host (
  // clock
  input  wire logic        i_clk,
  // register port
  output logic      [7:0]  o_addr,
  output logic      [31:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd,
  input  wire logic [31:0] i_rdata
);
  initial begin
    o_addr  = 8'h00;
    o_wdata = 32'h0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // idle lines carry the inverse of the last value so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= dat;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~dat;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    dat = i_rdata;
  endtask
  // value right-aligned at the destination width, bits above it cleared
  task automatic cmd(input logic [3:0] op, input logic [3:0] sel, input logic [3:0] hi,
                     input logic [3:0] lo, input logic [15:0] v, input int w);
    wr(`RCDL_A_CMD16, {v & 16'((32'h1 << w) - 1), hi, sel, lo, op});
  endtask
endmodule

// ### sim/test_rcdl_top.sv
// self-checking bench of the ramp command decoder
`timescale 1ns/1ps
`include "rcdl_params.svh"
module test_rcdl_top;
  logic        clk, nrst, wr, rd, stp_n, sld_n, sync_in, tgt, tlim;
  logic        halt, tick, sout, latch, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  mode, div;
  logic [23:0] rtime;
  logic [13:0] nacc, nvel, aacc, avel, slope;
  logic [12:0] sacc, svel;
  logic [1:0]  misc;
  logic [12:0] thr [4];
  logic [7:0]  cur [4];
  int          fails, samples_checked, cycles, w;

  rcdl_top u_rcdl_top (
    .I_CORE_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_LEFT_STOP_PIN_N(1'b1), .I_RIGHT_STOP_PIN_N(stp_n),
    .I_LEFT_SLOWDOWN_PIN_N(1'b1), .I_RIGHT_SLOWDOWN_PIN_N(sld_n), .I_SYNC_IN(sync_in),
    .I_ACCEL_REACHED(1'b0), .I_VEL_REACHED(1'b0), .I_TARGET_REACHED(tgt),
    .I_TIME_LIMIT_HIT(tlim), .O_RAMP_MODE(mode), .O_RAMP_HALT(halt), .O_RAMP_TICK(tick),
    .O_RAMP_TIME(rtime), .O_SYNC_OUT(sout), .O_LATCH(latch), .O_QUEUE_IRQ(irq),
    .O_NOM_ACCEL(nacc), .O_NOM_VEL(nvel), .O_ACT_ACCEL(aacc), .O_ACT_VEL(avel),
    .O_SLD_ACCEL(sacc), .O_SLD_VEL(svel), .O_ACCEL_SLOPE(slope), .O_RAMP_DIV(div),
    .O_MISC_CTRL(misc), .O_CMP_THRESH(thr), .O_MOTOR_CURRENT(cur)
  );
  rcdl_host u_rcdl_host (
    .i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim();
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    u_rcdl_host.rd(a, d);
    chk($sformatf("register %h", a), e, d);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] sel, input logic [3:0] hi,
                     input logic [3:0] lo, input logic [15:0] v, input int wd);
    u_rcdl_host.cmd(op, sel, hi, lo, v, wd);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic hit(input logic t, input logic l);
    @(posedge clk);
    tgt  <= t;
    tlim <= l;
    @(posedge clk);
    tgt  <= 1'b0;
    tlim <= 1'b0;
  endtask

  // hang guard, well above the length of the sequence below
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    {stp_n, sld_n, sync_in, tgt, tlim, nrst} = 6'b110000;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rchk(`RCDL_A_FUNC, 32'h1);
    rchk(`RCDL_A_QSTAT, 32'h0);
    u_rcdl_host.wr(`RCDL_A_INPUT, 32'hffffffff);
    rchk(`RCDL_A_INPUT, 32'h0);
    rchk(8'h10, 32'h0);
    for (int s = 0; s < 8; s++) begin
      w = (s == 7) ? 4 : ((s == 4 || s == 5) ? 13 : 14);
      cmd(4'ha, 4'(s), 4'h0, 4'h0, 16'h1000 + 16'(s) * 16'h0111, w);
    end
    cmd(4'ha, `RCDL_SEL_MISC, 4'h0, 4'h0, 16'h0002, 2);
    cmd(4'ha, `RCDL_SEL_NONE, 4'h0, 4'h0, 16'h0fff, 14);
    cyc(4);
    chk("nom accel", 32'h1000, 32'(nacc));
    chk("nom vel", 32'h1111, 32'(nvel));
    chk("act accel", 32'h1222, 32'(aacc));
    chk("act vel", 32'h1333, 32'(avel));
    chk("sld accel", 32'h1444, 32'(sacc));
    chk("sld vel", 32'h1555, 32'(svel));
    chk("slope", 32'h1666, 32'(slope));
    chk("divider", 32'h7, 32'(div));
    chk("misc", 32'h2, 32'(misc));
    for (int s = 0; s < 8; s++) begin
      cmd(`RCDL_OP_ANA, 4'(s), 4'h0, 4'h0, 16'(s < 4 ? 16'h0a00 + s : 16'h0040 + s), s < 4 ? 13 : 8);
    end
    cyc(4);
    for (int s = 0; s < 4; s++) begin
      chk("threshold", 32'h0a00 + 32'(s), 32'(thr[s]));
      chk("current", 32'h0044 + 32'(s), 32'(cur[s]));
    end
    cmd(4'ha, `RCDL_SEL_NONE, 4'h4, 4'h0, 16'h0, 1);
    cyc(4);
    chk("sync out", 32'h1, 32'(sout));
    u_rcdl_host.wr(`RCDL_A_CMD8, 32'h0000000a);
    cyc(4);
    chk("sync out kept", 32'h1, 32'(sout));
    cmd(4'ha, `RCDL_SEL_NONE, 4'h0, 4'h0, 16'h0, 1);
    cyc(4);
    chk("sync out", 32'h0, 32'(sout));
    // constant ramp without end flags, one entry waits behind it
    u_rcdl_host.wr(`RCDL_A_FUNC, 32'h0);
    rchk(`RCDL_A_FUNC, 32'h0);
    cmd(4'h2, `RCDL_SEL_NONE, 4'h0, 4'h0, 16'h0, 1);
    cmd(4'ha, `RCDL_SEL_ANOM, 4'h0, 4'h0, 16'h0123, 14);
    hit(1'b1, 1'b1);
    cyc(4);
    rchk(`RCDL_A_QSTAT, 32'h1);
    chk("nom accel held", 32'h1000, 32'(nacc));
    @(posedge clk);
    stp_n <= 1'b0;
    cyc(4);
    rchk(`RCDL_A_INPUT, 32'h4);
    chk("halt disabled", 32'h0, 32'(halt));
    stp_n <= 1'b1;
    u_rcdl_host.wr(`RCDL_A_FUNC, 32'h1);
    @(posedge clk);
    stp_n <= 1'b0;
    cyc(6);
    chk("halt", 32'h1, 32'(halt));
    chk("stop vel", 32'h0, 32'(avel));
    chk("queue resumed", 32'h0123, 32'(nacc));
    stp_n <= 1'b1;
    rchk(`RCDL_A_QSTAT, 32'h1000);
    rchk(`RCDL_A_QSTAT, 32'h0);
    for (int k = 0; k < 2; k++) begin
      cmd(4'h2, `RCDL_SEL_NONE, 4'(1 << k), 4'h0, 16'h0, 1);
      cmd(4'ha, `RCDL_SEL_ANOM, 4'h0, 4'h0, 16'h0200 + 16'(k), 14);
      hit(k == 0, k == 1);
      cyc(4);
      chk("end flag", 32'h0200 + 32'(k), 32'(nacc));
    end
    chk("halt cleared", 32'h0, 32'(halt));
    // slowdown: 100 down to 50 in steps of 10, ramp clock every second cycle
    u_rcdl_host.wr(`RCDL_A_FUNC, 32'h3);
    cmd(4'ha, `RCDL_SEL_DIV, 4'h0, 4'h0, 16'h0, 4);
    cmd(4'ha, `RCDL_SEL_AVEL, 4'h0, 4'h0, 16'd100, 14);
    cmd(4'ha, `RCDL_SEL_ASLD, 4'h0, 4'h0, 16'd10, 13);
    cmd(4'ha, `RCDL_SEL_VSLD, 4'h0, 4'h0, 16'd50, 13);
    cmd(4'h2, `RCDL_SEL_NONE, 4'h2, 4'h0, 16'h0, 1);
    @(posedge clk);
    sld_n <= 1'b0;
    cyc(60);
    chk("slowdown mode", 32'(`RCDL_OP_LIN), 32'(mode));
    chk("slowdown vel", 32'd50, 32'(avel));
    rchk(`RCDL_A_QSTAT, 32'h2000);
    hit(1'b0, 1'b1);
    sld_n <= 1'b1;
    cyc(4);
    rchk(`RCDL_A_QSTAT, 32'h2000);
    rchk(`RCDL_A_QSTAT, 32'h0);
    cmd(`RCDL_OP_AUTO, `RCDL_SEL_NONE, 4'h0, 4'h0, 16'h0, 1);
    cyc(4);
    rchk(`RCDL_A_QSTAT, 32'h0800);
    @(posedge clk);
    sld_n <= 1'b0;
    cyc(6);
    chk("auto killed", 32'h1, 32'(halt));
    chk("auto vel", 32'h0, 32'(avel));
    sld_n <= 1'b1;
    // reference search: ramp runs, override entry waits for sync high
    cmd(4'h2, `RCDL_SEL_NONE, 4'h2, 4'h0, 16'h0, 1);
    cmd(4'ha, `RCDL_SEL_VNOM, 4'h0, 4'h0, 16'h0345, 14);
    cmd(4'ha, `RCDL_SEL_AACC, 4'h0, 4'hf, 16'h0456, 14);
    cyc(4);
    chk("override flush", 32'h0345, 32'(nvel));
    hit(1'b0, 1'b1);
    cyc(8);
    chk("sync wait", 32'h1222, 32'(aacc));
    @(posedge clk);
    sync_in <= 1'b1;
    for (int n = 0; n < 20 && latch !== 1'b1; n++) begin
      @(negedge clk);
    end
    chk("latch", 32'h1, 32'(latch));
    chk("queue irq", 32'h1, 32'(irq));
    cyc(2);
    chk("sync start", 32'h0456, 32'(aacc));
    rchk(`RCDL_A_INPUT, 32'h10);
    chk("time runs", 32'h1, 32'(rtime > 24'd8));
    cmd(4'ha, `RCDL_SEL_NONE, 4'h8, 4'h0, 16'h0, 1);
    cyc(3);
    chk("time cleared", 32'h1, 32'(rtime < 24'd8));
    end_sim();
  end
endmodule
